// ===== core/spcmd_pkg.sv
// Functional notes
// - Opcode FAh 3/4-byte address; E0h 4-byte.
// - Address, then 8-bit dynamic byte on falling edges.
// - Dynamic byte repeats every eight bits, no advance.
// - FBh/E1h dynamic write with one data byte.
// - Dynamic write needs write enable latch set.
// - Dynamic write starts when chip select rises.
// - FCh/E2h persistent read, single-line only.
// - Persistent byte repeats; address never advances.
// - FDh/E3h program persistent bit, no data.
// - Persistent program busy, then latch clears.
// - E4h erases all persistent bits, exact length.
// - Erase busy throughout; suspend refused; latch clears.
// - 2Bh shifts config low byte first, repeats.
// - 2Fh two data bytes, exact sixteen bits.
// - Config program busy, then latch clears.
// - A7h lock read: single-line, idle only.
// - A6h clears lock bit; busy; latch clears.
// - Extended-address bit set/cleared by B7h/29h.
package spcmd_pkg;

  localparam logic [7:0] OP_READ_DYN      = 8'hFA;
  localparam logic [7:0] OP_READ_DYN_W    = 8'hE0;
  localparam logic [7:0] OP_WRITE_DYN     = 8'hFB;
  localparam logic [7:0] OP_WRITE_DYN_W   = 8'hE1;
  localparam logic [7:0] OP_READ_PERS     = 8'hFC;
  localparam logic [7:0] OP_READ_PERS_W   = 8'hE2;
  localparam logic [7:0] OP_PROG_PERS     = 8'hFD;
  localparam logic [7:0] OP_PROG_PERS_W   = 8'hE3;
  localparam logic [7:0] OP_ERASE_PERS    = 8'hE4;
  localparam logic [7:0] OP_READ_CFG      = 8'h2B;
  localparam logic [7:0] OP_PROG_CFG      = 8'h2F;
  localparam logic [7:0] OP_READ_LOCK     = 8'hA7;
  localparam logic [7:0] OP_CLEAR_LOCK    = 8'hA6;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_ENTER_WIDE    = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE     = 8'h29;

  localparam logic [6:0] OPCODE_BITS = 7'h08;
  localparam logic [6:0] ADDR3_BITS  = 7'h18;
  localparam logic [6:0] ADDR4_BITS  = 7'h20;
  localparam logic [6:0] BYTE_BITS   = 7'h08;
  localparam logic [6:0] CFG_BITS    = 7'h10;
  localparam logic [6:0] BITS_MAX    = 7'h7F;

  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned PROG_TIME_US   = 1000;
  localparam int unsigned ERASE_TIME_US  = 50000;
  localparam int unsigned PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;

  localparam int unsigned SECT_LSB_DEF = 16;
  localparam int unsigned NUM_SECT_DEF = 512;

  localparam logic [15:0] CFG_RESET  = 16'hFFFF;
  localparam logic        LOCK_RESET = 1'h1;
  localparam logic        EXT_RESET  = 1'h0;
  localparam logic        DYN_RESET  = 1'h1;
  localparam logic        PERS_RESET = 1'h1;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_RX   = 3'b010,
    LINK_TX   = 3'b100
  } spcmd_link_t;

  typedef enum logic [3:0] {
    JOB_PERS  = 4'b0001,
    JOB_ERASE = 4'b0010,
    JOB_CFG   = 4'b0100,
    JOB_LOCK  = 4'b1000
  } spcmd_job_t;

  // Number of address bits that follow the opcode.
  function automatic logic [6:0] addr_bits(input logic [7:0] op,
                                           input logic       ext);
    unique case (op)
      OP_READ_DYN_W, OP_WRITE_DYN_W, OP_READ_PERS_W,
      OP_PROG_PERS_W: addr_bits = ADDR4_BITS;
      default:        addr_bits = ext ? ADDR4_BITS : ADDR3_BITS;
    endcase
  endfunction

endpackage

// ===== core/spcmd_store_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spcmd_store_if #(parameter int unsigned SECT_W = 9);
  logic [SECT_W-1:0] sector;
  logic              wr_dyn;
  logic              dyn_val;
  logic              prog_pers;
  logic              erase_pers;
  logic              dyn_bit;
  logic              pers_bit;

  modport ctrl  (output sector, wr_dyn, dyn_val, prog_pers, erase_pers,
                 input  dyn_bit, pers_bit);
  modport store (input  sector, wr_dyn, dyn_val, prog_pers, erase_pers,
                 output dyn_bit, pers_bit);
endinterface
`default_nettype wire

// ===== core/spcmd_prot_store.sv
`timescale 1ns/1ps
`default_nettype none
module spcmd_prot_store #(
  parameter int unsigned NUM_SECT = spcmd_pkg::NUM_SECT_DEF
) (
  input  wire logic    clk_i,
  input  wire logic    reset_n_i,
  input  wire logic    ce_i,
  spcmd_store_if.store st
);
  import spcmd_pkg::*;

  logic [NUM_SECT-1:0] dyn;
  logic [NUM_SECT-1:0] pers;
  logic [NUM_SECT-1:0] next_dyn;
  logic [NUM_SECT-1:0] next_pers;

  always_comb begin
    next_dyn  = dyn;
    next_pers = pers;
    if (st.wr_dyn) begin
      next_dyn[st.sector] = st.dyn_val;
    end
    // Programming a persistent bit protects the sector (bit to 0).
    if (st.prog_pers) begin
      next_pers[st.sector] = 1'h0;
    end
    if (st.erase_pers) begin
      next_pers = '1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dyn  <= {NUM_SECT{DYN_RESET}};
      pers <= {NUM_SECT{PERS_RESET}};
    end else if (ce_i) begin
      dyn  <= next_dyn;
      pers <= next_pers;
    end
  end

  assign st.dyn_bit  = dyn[st.sector];
  assign st.pers_bit = pers[st.sector];
endmodule
`default_nettype wire

// ===== core/spcmd_handler.sv
`timescale 1ns/1ps
`default_nettype none
module spcmd_handler #(
  parameter int unsigned SECT_LSB     = spcmd_pkg::SECT_LSB_DEF,
  parameter int unsigned NUM_SECT     = spcmd_pkg::NUM_SECT_DEF,
  parameter int unsigned PROG_CYCLES  = spcmd_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = spcmd_pkg::ERASE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        si_i,
  input  wire logic        quad_mode_i,
  output logic             so_o,
  output logic             so_oe_o,
  output logic             wip_o,
  output logic             wel_o,
  output logic             ext_addr_o,
  output logic             suspend_ok_o,
  output logic             lock_bit_o,
  output logic [15:0]      cfg_o
);
  import spcmd_pkg::*;

  localparam int unsigned SECT_W = $clog2(NUM_SECT);

  spcmd_store_if #(.SECT_W(SECT_W)) st_if ();

  spcmd_prot_store #(.NUM_SECT(NUM_SECT)) u_store (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .st        (st_if.store)
  );

  // Pin synchronisers and edge history.
  logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2;
  logic next_cs_s1, next_cs_s2, next_cs_d;
  logic next_sck_s1, next_sck_s2, next_sck_d, next_si_s1, next_si_s2;

  always_comb begin
    next_cs_s1  = cs_n_i;
    next_cs_s2  = cs_s1;
    next_cs_d   = cs_s2;
    next_sck_s1 = sck_i;
    next_sck_s2 = sck_s1;
    next_sck_d  = sck_s2;
    next_si_s1  = si_i;
    next_si_s2  = si_s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_s1  <= 1'h1;
      cs_s2  <= 1'h1;
      cs_d   <= 1'h1;
      sck_s1 <= 1'h0;
      sck_s2 <= 1'h0;
      sck_d  <= 1'h0;
      si_s1  <= 1'h0;
      si_s2  <= 1'h0;
    end else if (ce_i) begin
      cs_s1  <= next_cs_s1;
      cs_s2  <= next_cs_s2;
      cs_d   <= next_cs_d;
      sck_s1 <= next_sck_s1;
      sck_s2 <= next_sck_s2;
      sck_d  <= next_sck_d;
      si_s1  <= next_si_s1;
      si_s2  <= next_si_s2;
    end
  end

  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck_s2 & ~sck_d;
  assign sck_fall = ~sck_s2 & sck_d;
  assign cs_rise  = cs_s2 & ~cs_d;

  // Frame state.
  spcmd_link_t link, next_link;
  logic [6:0]  bits, next_bits;
  logic [31:0] sreg, next_sreg;
  logic [31:0] alat, next_alat;
  logic [7:0]  opcode, next_opcode;
  logic [15:0] out_word, next_out_word;
  logic [3:0]  out_cnt, next_out_cnt;
  logic        so, next_so, so_oe, next_so_oe;

  // Execution state.
  logic              write_in_progress, next_wip, write_enable_latch, next_wel, ext, next_ext;
  logic              lock, next_lock, susp_ok, next_susp_ok;
  logic [15:0]       cfg, next_cfg, cfg_pend, next_cfg_pend;
  spcmd_job_t        job, next_job;
  logic [31:0]       timer, next_timer;
  logic [SECT_W-1:0] job_sect, next_job_sect;

  logic [6:0]        alen;
  logic [31:0]       addr;
  logic [SECT_W-1:0] addr_sect;
  logic              op_known, rd_ok;
  logic [6:0]        rd_start;
  logic [15:0]       rd_word;
  logic [7:0]        dyn_byte, pers_byte;

  assign alen      = addr_bits(opcode, ext);
  assign addr      = (alen == ADDR4_BITS) ? alat : {8'h00, alat[23:0]};
  assign addr_sect = addr[SECT_LSB +: SECT_W];
  assign op_known  = (bits >= OPCODE_BITS);
  assign dyn_byte  = {8{st_if.dyn_bit}};
  assign pers_byte = {8{st_if.pers_bit}};

  assign st_if.sector = write_in_progress ? job_sect : addr_sect;

  // Read decode: what to shift out, and after how many input bits.
  always_comb begin
    rd_ok    = 1'h0;
    rd_start = OPCODE_BITS;
    rd_word  = {out_word};
    if (op_known) begin
      unique case (opcode)
        OP_READ_DYN, OP_READ_DYN_W: begin
          rd_ok    = ~write_in_progress;
          rd_start = OPCODE_BITS + alen;
          rd_word  = {dyn_byte, dyn_byte};
        end
        OP_READ_PERS, OP_READ_PERS_W: begin
          rd_ok    = ~write_in_progress & ~quad_mode_i;
          rd_start = OPCODE_BITS + alen;
          rd_word  = {pers_byte, pers_byte};
        end
        OP_READ_CFG: begin
          rd_ok   = ~write_in_progress;
          rd_word = {cfg[7:0], cfg[15:8]};
        end
        OP_READ_LOCK: begin
          rd_ok   = ~write_in_progress & ~quad_mode_i;
          rd_word = {7'h00, lock, 7'h00, lock};
        end
        OP_READ_STATUS: begin
          rd_ok   = 1'h1;
          rd_word = {6'h00, write_enable_latch, write_in_progress, 6'h00, write_enable_latch, write_in_progress};
        end
        default: rd_ok = 1'h0;
      endcase
    end
  end

  always_comb begin
    next_link     = link;
    next_bits     = bits;
    next_sreg     = sreg;
    next_alat     = alat;
    next_opcode   = opcode;
    next_out_word = out_word;
    next_out_cnt  = out_cnt;
    next_so       = so;
    next_so_oe    = so_oe;
    if (cs_s2) begin
      next_link    = LINK_IDLE;
      next_bits    = 7'h00;
      next_out_cnt = 4'h0;
      next_so_oe   = 1'h0;
    end else begin
      if (link == LINK_IDLE) begin
        next_link = LINK_RX;
      end
      if (sck_rise && link != LINK_TX) begin
        next_sreg = {sreg[30:0], si_s2};
        if (bits != BITS_MAX) begin
          next_bits = bits + 7'h01;
        end
        if (bits == OPCODE_BITS - 7'h01) begin
          next_opcode = {sreg[6:0], si_s2};
        end
        if (bits == OPCODE_BITS + alen - 7'h01) begin
          // Freeze the address once complete; data bits keep shifting
          // into sreg behind it.
          next_alat = {sreg[30:0], si_s2};
        end
      end
      // Output changes on falling edges and wraps every sixteen bits.
      if (sck_fall && rd_ok && link == LINK_RX && bits == rd_start) begin
        next_link     = LINK_TX;
        next_out_word = rd_word;
        next_so       = rd_word[15];
        next_so_oe    = 1'h1;
        next_out_cnt  = 4'h1;
      end else if (sck_fall && link == LINK_TX) begin
        next_so      = out_word[4'hF - out_cnt];
        next_out_cnt = out_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link     <= LINK_IDLE;
      bits     <= 7'h00;
      sreg     <= 32'h0000_0000;
      alat     <= 32'h0000_0000;
      opcode   <= 8'h00;
      out_word <= 16'h0000;
      out_cnt  <= 4'h0;
      so       <= 1'h0;
      so_oe    <= 1'h0;
    end else if (ce_i) begin
      link     <= next_link;
      bits     <= next_bits;
      sreg     <= next_sreg;
      alat     <= next_alat;
      opcode   <= next_opcode;
      out_word <= next_out_word;
      out_cnt  <= next_out_cnt;
      so       <= next_so;
      so_oe    <= next_so_oe;
    end
  end

  // Command execution at the end of a frame, and the busy timer.
  logic commit, can_write;
  assign commit    = cs_rise && op_known && link == LINK_RX;
  assign can_write = ~write_in_progress & write_enable_latch;
  // A write counts only if chip select rises right after its last bit.

  always_comb begin
    next_wip        = write_in_progress;
    next_wel        = write_enable_latch;
    next_ext        = ext;
    next_lock       = lock;
    next_cfg        = cfg;
    next_cfg_pend   = cfg_pend;
    next_job        = job;
    next_timer      = timer;
    next_job_sect   = job_sect;
    st_if.wr_dyn    = 1'h0;
    st_if.dyn_val   = sreg[0];
    st_if.prog_pers = 1'h0;
    st_if.erase_pers = 1'h0;
    if (write_in_progress) begin
      next_timer = timer - 32'h0000_0001;
      if (timer == 32'h0000_0001) begin
        next_wip = 1'h0;
        next_wel = 1'h0;
        unique case (job)
          JOB_PERS:  st_if.prog_pers  = 1'h1;
          JOB_ERASE: st_if.erase_pers = 1'h1;
          JOB_CFG:   next_cfg         = cfg_pend;
          JOB_LOCK:  next_lock        = 1'h0;
          default:   next_lock        = lock;
        endcase
      end
    end else if (commit) begin
      unique case (opcode)
        OP_WRITE_ENABLE: begin
          if (bits == OPCODE_BITS) next_wel = 1'h1;
        end
        OP_ENTER_WIDE: begin
          if (bits == OPCODE_BITS) next_ext = 1'h1;
        end
        OP_EXIT_WIDE: begin
          if (bits == OPCODE_BITS) next_ext = 1'h0;
        end
        OP_WRITE_DYN, OP_WRITE_DYN_W: begin
          if (can_write && bits == OPCODE_BITS + alen + BYTE_BITS) begin
            st_if.wr_dyn = 1'h1;
            next_wel     = 1'h0;
          end
        end
        OP_PROG_PERS, OP_PROG_PERS_W: begin
          if (can_write && bits == OPCODE_BITS + alen) begin
            next_wip      = 1'h1;
            next_job      = JOB_PERS;
            next_job_sect = addr_sect;
            next_timer    = PROG_CYCLES[31:0];
          end
        end
        OP_ERASE_PERS: begin
          if (can_write && bits == OPCODE_BITS) begin
            next_wip   = 1'h1;
            next_job   = JOB_ERASE;
            next_timer = ERASE_CYCLES[31:0];
          end
        end
        OP_PROG_CFG: begin
          if (can_write && bits == OPCODE_BITS + CFG_BITS) begin
            next_wip      = 1'h1;
            next_job      = JOB_CFG;
            next_cfg_pend = {sreg[7:0], sreg[15:8]};
            next_timer    = PROG_CYCLES[31:0];
          end
        end
        OP_CLEAR_LOCK: begin
          if (can_write && bits == OPCODE_BITS) begin
            next_wip   = 1'h1;
            next_job   = JOB_LOCK;
            next_timer = PROG_CYCLES[31:0];
          end
        end
        default: next_wip = 1'h0;
      endcase
    end
    next_susp_ok = ~(next_wip && next_job == JOB_ERASE);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_in_progress      <= 1'h0;
      write_enable_latch      <= 1'h0;
      ext      <= EXT_RESET;
      lock     <= LOCK_RESET;
      cfg      <= CFG_RESET;
      cfg_pend <= CFG_RESET;
      job      <= JOB_PERS;
      timer    <= 32'h0000_0000;
      job_sect <= '0;
      susp_ok  <= 1'h1;
    end else if (ce_i) begin
      write_in_progress      <= next_wip;
      write_enable_latch      <= next_wel;
      ext      <= next_ext;
      lock     <= next_lock;
      cfg      <= next_cfg;
      cfg_pend <= next_cfg_pend;
      job      <= next_job;
      timer    <= next_timer;
      job_sect <= next_job_sect;
      susp_ok  <= next_susp_ok;
    end
  end

  assign so_o         = so;
  assign so_oe_o      = so_oe;
  assign wip_o        = write_in_progress;
  assign wel_o        = write_enable_latch;
  assign ext_addr_o   = ext;
  assign suspend_ok_o = susp_ok;
  assign lock_bit_o   = lock;
  assign cfg_o        = cfg;
endmodule
`default_nettype wire

// ===== tb/spcmd_handler_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spcmd_handler_assertions (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        ce_i,
  input wire logic        cs_n_i,
  input wire logic        sck_i,
  input wire logic        si_i,
  input wire logic        quad_mode_i,
  input wire logic        so_o,
  input wire logic        so_oe_o,
  input wire logic        wip_o,
  input wire logic        wel_o,
  input wire logic        ext_addr_o,
  input wire logic        suspend_ok_o,
  input wire logic        lock_bit_o,
  input wire logic [15:0] cfg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_oe_after_deselect: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("so_oe_o high while deselected");
  a_wel_cleared_done: assert property ($fell(wip_o) |-> !wel_o)
    else $error("wel_o still set after busy ended");
  a_suspend_in_busy: assert property (!suspend_ok_o |-> wip_o)
    else $error("suspend refused while idle");
  a_busy_needs_wel: assert property ($rose(wip_o) |-> $past(wel_o))
    else $error("busy started without write enable");
  a_busy_after_deselect: assert property (
    $rose(wip_o) |-> $past(cs_n_i, 2))
    else $error("busy started while selected");
  a_cfg_at_end: assert property (
    $changed(cfg_o) |-> $past(wip_o) || $past(wip_o, 2))
    else $error("cfg_o changed outside a program");
  a_lock_at_end: assert property (
    $changed(lock_bit_o) |-> $past(wip_o) || $past(wip_o, 2))
    else $error("lock_bit_o changed outside a program");
  a_ext_held_busy: assert property (
    $past(wip_o) && wip_o |-> $stable(ext_addr_o))
    else $error("ext_addr_o changed while busy");
endmodule

bind spcmd_handler spcmd_handler_assertions spcmd_handler_assertions_inst (
  .clk_i, .reset_n_i, .ce_i, .cs_n_i, .sck_i, .si_i, .quad_mode_i, .so_o,
  .so_oe_o, .wip_o, .wel_o, .ext_addr_o, .suspend_ok_o, .lock_bit_o, .cfg_o
);
`default_nettype wire

// ===== tb/spcmd_host.sv
`timescale 1ns/1ps
`default_nettype none
module spcmd_host (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic oe_seen;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    oe_seen = 1'b0;
  end

  // Mode 0 frame: ntx bits out MSB first, then nrx bits captured.
  task automatic frame(input logic [47:0] tx, input int ntx,
                       input int nrx, output logic [31:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n_o = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      sck_o = 1'b0;
      si_o = (i < ntx) ? tx[ntx-1-i] : ~si_o;
      #62.5;
      if (i >= ntx) begin
        // A released line reads back as the inverse of its last level.
        rx = {rx[30:0], so_oe_i ? so_i : ~so_i};
        oe_seen = oe_seen | so_oe_i;
      end
      sck_o = 1'b1;
      #62.5;
    end
    sck_o = 1'b0;
    #62.5;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #100;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spcmd_pkg::*;
  logic        clk_i;
  logic        reset_n_i;
  logic        quad_mode_i;
  logic        cs_n, sck, si, so, so_oe, write_in_progress, write_enable_latch, ext, susp, lock;
  logic [15:0] cfg;
  logic [31:0] rx;
  int          mismatches = 0;
  int          checks_done = 0;

  spcmd_handler #(.PROG_CYCLES(20), .ERASE_CYCLES(400)) spcmd_handler_inst (
    .clk_i, .reset_n_i, .ce_i(1'b1), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .quad_mode_i, .so_o(so), .so_oe_o(so_oe), .wip_o(write_in_progress),
    .wel_o(write_enable_latch), .ext_addr_o(ext), .suspend_ok_o(susp),
    .lock_bit_o(lock), .cfg_o(cfg));
  spcmd_host spcmd_host_inst (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input logic [47:0] tx, input int ntx, input int nrx);
    @(negedge clk_i);
    spcmd_host_inst.frame(tx, ntx, nrx, rx);
  endtask

  task automatic set_quad(input logic v);
    @(negedge clk_i);
    quad_mode_i = v;
  endtask

  task automatic write_enable_instruction;
    cmd(40'(OP_WRITE_ENABLE), 8, 0);
  endtask

  // Polls status until idle; both busy and write enable must read 0.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      cmd(40'(OP_READ_STATUS), 8, 8);
      n++;
    end while (rx[0] !== 1'b0 && n < 20);
    check("status", rx, 32'h0);
  endtask

  task automatic t_reset;
    check("reset", 32'({write_in_progress, write_enable_latch, ext, susp, lock, cfg}),
          32'({5'b00011, CFG_RESET}));
  endtask

  task automatic t_dyn;
    cmd(40'({OP_READ_DYN, 24'h030000}), 32, 16);
    check("dyn repeat", rx, 32'hFFFF);
    cmd(40'({OP_WRITE_DYN, 24'h030000, 8'h00}), 40, 0);
    cmd(40'({OP_READ_DYN, 24'h030000}), 32, 8);
    check("dyn no wel", rx, 32'hFF);
    write_enable_instruction;
    check("wel", 32'(write_enable_latch), 32'h1);
    cmd(40'({OP_WRITE_DYN, 24'h030000, 8'h00}), 40, 0);
    check("dyn write", 32'({write_enable_latch, write_in_progress}), 32'h0);
    cmd(40'({OP_READ_DYN_W, 32'h00030000}), 40, 16);
    check("dyn wide", rx, 32'h0);
    cmd(40'({OP_READ_DYN, 24'h040000}), 32, 8);
    check("dyn other", rx, 32'hFF);
    write_enable_instruction;
    cmd({OP_WRITE_DYN_W, 32'h00030000, 8'hFF}, 48, 0);
    cmd(40'({OP_READ_DYN, 24'h030000}), 32, 8);
    check("dyn wide wr", rx, 32'hFF);
  endtask

  task automatic t_pers;
    write_enable_instruction;
    cmd(40'({OP_PROG_PERS, 24'h050000}), 32, 0);
    check("pers busy", 32'({write_in_progress, susp}), 32'h3);
    wait_idle;
    cmd(40'({OP_READ_PERS, 24'h050000}), 32, 16);
    check("pers repeat", rx, 32'h0);
    set_quad(1'b1);
    cmd(40'({OP_READ_PERS, 24'h050000}), 32, 8);
    check("pers quad", 32'(spcmd_host_inst.oe_seen), 32'h0);
    set_quad(1'b0);
    cmd(40'(OP_ENTER_WIDE), 8, 0);
    check("ext set", 32'(ext), 32'h1);
    cmd(40'({OP_READ_PERS, 32'h00050000}), 40, 8);
    check("pers wide", rx, 32'h0);
    write_enable_instruction;
    cmd(40'({OP_PROG_PERS_W, 32'h00060000}), 40, 0);
    wait_idle;
    cmd(40'({OP_READ_PERS, 32'h00060000}), 40, 8);
    check("pers prog w", rx, 32'h0);
    cmd(40'(OP_EXIT_WIDE), 8, 0);
    check("ext clear", 32'(ext), 32'h0);
    write_enable_instruction;
    cmd(40'({OP_ERASE_PERS, 1'b0}), 9, 0);
    check("erase len", 32'(write_in_progress), 32'h0);
    write_enable_instruction;
    cmd(40'(OP_ERASE_PERS), 8, 0);
    check("erase busy", 32'({write_in_progress, susp}), 32'h2);
    cmd(40'(OP_READ_LOCK), 8, 8);
    check("lock busy rd", 32'(spcmd_host_inst.oe_seen), 32'h0);
    cmd(40'(OP_READ_STATUS), 8, 8);
    check("status busy", rx, 32'h3);
    wait_idle;
    cmd(40'({OP_READ_PERS_W, 32'h00050000}), 40, 8);
    check("erased", rx, 32'hFF);
  endtask

  task automatic t_cfg;
    cmd(40'(OP_READ_CFG), 8, 32);
    check("cfg read", rx, 32'hFFFFFFFF);
    write_enable_instruction;
    cmd(40'({OP_PROG_CFG, 15'h0}), 23, 0);
    check("cfg short", 32'({write_in_progress, cfg}), 32'h0FFFF);
    write_enable_instruction;
    cmd(40'({OP_PROG_CFG, 8'hA5, 8'h3C}), 24, 0);
    check("cfg busy", 32'(write_in_progress), 32'h1);
    wait_idle;
    check("cfg value", 32'(cfg), 32'h3CA5);
    cmd(40'(OP_READ_CFG), 8, 32);
    check("cfg order", rx, 32'hA53CA53C);
  endtask

  task automatic t_lock;
    set_quad(1'b1);
    cmd(40'(OP_READ_LOCK), 8, 8);
    check("lock quad", 32'(spcmd_host_inst.oe_seen), 32'h0);
    set_quad(1'b0);
    cmd(40'(OP_READ_LOCK), 8, 16);
    check("lock read", rx, 32'h0101);
    write_enable_instruction;
    cmd(40'(OP_CLEAR_LOCK), 8, 0);
    check("lock busy", 32'(write_in_progress), 32'h1);
    wait_idle;
    cmd(40'(OP_READ_LOCK), 8, 8);
    check("lock clear", 32'({lock, rx[7:0]}), 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    reset_n_i = 1'b0;
    quad_mode_i = 1'b0;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_reset;
    t_dyn;
    t_pers;
    t_cfg;
    t_lock;
    report_and_stop;
  end

  initial begin
    #500000;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
